//--- pkg/kpr_pkg.sv
// Constants and types for the keyboard pointer reporter
// What this block does
// - Release sends press code with MSB set
// - Repeat delay and interval, 10ms units
// - Held key resends last code each interval
// - ALT combos intercepted, only ALT forwarded
// - Held combo repeats at key repeat rate
// - Pot values stay inside 99 steps
// - ALT+UP decrements brightness pot value
// - ALT+DOWN increments; contrast works alike
// - Reset combo sets status, resets 100ms
// - Other non-button key codes go to host
// - Four pressure channels, two per axis
// - Baseline captured at init, deltas mean pressure
// - Axis motion from opposing sensor difference
// - Packet is FD, status, X, Y
// - Status byte bit layout as given
// - Magnitudes 0 to 7, overflow zero
// - Eight pressure levels per scan
// - Event flag cleared at init, buttons set it
// - Motion fills signs, magnitudes, event flag
// - Scan end sends packet on event or motion, clears flag
// - Scan period in 10ms units, kept
// - Host command bytes answered with FE first, operands not
`default_nettype none
package kpr_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RESET_MS = 100;
    localparam logic [7:0] RESET_TICKS = 8'(RESET_MS / TICK_MS);
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_DLY_LSB = 0;
    localparam int CTRL_INT_LSB = 8;
    localparam int CTRL_SCAN_LSB = 16;
    localparam int STAT_BRI_LSB = 0;
    localparam int STAT_CON_LSB = 8;
    localparam int STAT_URST_BIT = 16;
    localparam int STAT_CAL_BIT = 17;
    // Reset values
    localparam logic [7:0] DLY_RST = 8'h32;
    localparam logic [7:0] INT_RST = 8'h05;
    localparam logic [7:0] SCAN_RST = 8'h02;
    localparam logic [6:0] POT_MAX = 7'h62;
    localparam logic [6:0] POT_RST = 7'h31;
    // Link bytes
    localparam logic [7:0] PKT_HDR = 8'hFD;
    localparam logic [7:0] ACK_BYTE = 8'hFE;
    localparam logic [7:0] CMD_SET_DLY = 8'h30;
    localparam logic [7:0] CMD_SET_INT = 8'h31;
    localparam logic [7:0] CMD_SET_SCAN = 8'h32;
    // Status byte fields
    localparam int ST_YNEG = 5;
    localparam int ST_XNEG = 4;
    localparam int ST_EVT = 3;
    // Scanner key codes
    localparam logic [6:0] KC_ALT = 7'h38;
    localparam logic [6:0] KC_UP = 7'h48;
    localparam logic [6:0] KC_DOWN = 7'h50;
    localparam logic [6:0] KC_LEFT = 7'h4B;
    localparam logic [6:0] KC_RIGHT = 7'h4D;
    localparam logic [6:0] KC_ESC = 7'h01;
    localparam logic [6:0] KC_R = 7'h13;
    localparam logic [6:0] KC_BTN_L = 7'h3B;
    localparam logic [6:0] KC_BTN_R = 7'h3C;
    localparam logic [6:0] KC_BTN_M = 7'h3D;
    // Held-key slots
    localparam logic [3:0] H_ALT = 4'h0;
    localparam logic [3:0] H_UP = 4'h1;
    localparam logic [3:0] H_DOWN = 4'h2;
    localparam logic [3:0] H_LEFT = 4'h3;
    localparam logic [3:0] H_RIGHT = 4'h4;
    localparam logic [3:0] H_ESC = 4'h5;
    localparam logic [3:0] H_R = 4'h6;
    localparam logic [3:0] H_BL = 4'h7;
    localparam logic [3:0] H_BR = 4'h8;
    localparam logic [3:0] H_BM = 4'h9;
    localparam logic [3:0] H_NONE = 4'hF;
    localparam int NKEYS = 10;
    // Pressure quantiser
    localparam logic [11:0] DEAD_BAND = 12'h008;
    localparam int LEVEL_SHIFT = 3;
    typedef enum logic {HOST_CMD, HOST_ARG} host_state_t;
endpackage : kpr_pkg
`default_nettype wire

//--- logic/byte_sender.sv
// Byte sequencer that plays up to four bytes onto the host link
`timescale 1ns/1ps
`default_nettype none
module byte_sender (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [2:0] len,
    input wire logic [31:0] bytes,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic busy
);
    logic [31:0] sh_ff;
    logic [2:0] cnt_ff;

    // First byte sits in the top lane; shift on each accepted byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff <= 32'h00000000;
            cnt_ff <= 3'h0;
        end else if (load && cnt_ff == 3'h0) begin
            sh_ff <= bytes;
            cnt_ff <= len;
        end else if (cnt_ff != 3'h0 && tx_ready) begin
            sh_ff <= {sh_ff[23:0], 8'h00};
            cnt_ff <= cnt_ff - 3'h1;
        end
    end

    assign tx_valid = cnt_ff != 3'h0;
    assign tx_data = sh_ff[31:24];
    assign busy = cnt_ff != 3'h0;
endmodule : byte_sender
`default_nettype wire

//--- logic/keyboard_pointer_reporter.sv
// Keyboard and pressure-pad pointer reporter with APB registers
`timescale 1ns/1ps
`default_nettype none
module keyboard_pointer_reporter
    import kpr_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic key_valid,
    input wire logic [6:0] key_code,
    input wire logic key_release,
    output logic key_ready,
    input wire logic adc_valid,
    input wire logic [9:0] adc_up,
    input wire logic [9:0] adc_down,
    input wire logic [9:0] adc_left,
    input wire logic [9:0] adc_right,
    input wire logic host_valid,
    input wire logic [7:0] host_data,
    output logic host_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic [6:0] bright_pot,
    output logic [6:0] contrast_pot,
    output logic sys_reset_n,
    output logic user_reset
);
    // Maps a scanner code onto its held-key slot
    function automatic logic [3:0] key_idx(input logic [6:0] c);
        logic [3:0] r;
        r = H_NONE;
        if (c == KC_ALT) r = H_ALT;
        else if (c == KC_UP) r = H_UP;
        else if (c == KC_DOWN) r = H_DOWN;
        else if (c == KC_LEFT) r = H_LEFT;
        else if (c == KC_RIGHT) r = H_RIGHT;
        else if (c == KC_ESC) r = H_ESC;
        else if (c == KC_R) r = H_R;
        else if (c == KC_BTN_L) r = H_BL;
        else if (c == KC_BTN_R) r = H_BR;
        else if (c == KC_BTN_M) r = H_BM;
        return r;
    endfunction : key_idx

    // Axis difference to {moved, negative, level}
    function automatic logic [4:0] quant(input logic [11:0] d);
        logic [11:0] m;
        logic [11:0] lv;
        m = d[11] ? 12'(-d) : d;
        lv = 12'h000;
        if (m >= DEAD_BAND) lv = (m - DEAD_BAND) >> LEVEL_SHIFT;
        if (lv > 12'h007) lv = 12'h007;
        return {m >= DEAD_BAND, d[11], lv[2:0]};
    endfunction : quant

    logic [7:0] dly_ff, int_ff, scan_ff;
    logic [31:0] prdata_ff;
    logic [17:0] tick_cnt_ff;
    logic tick;
    logic [NKEYS-1:0] held_ff;
    logic [3:0] kidx;
    logic key_take, intercept, button, fwd;
    logic key_pend_ff, rep_pend_ff, ack_pend_ff, pkt_pend_ff;
    logic [7:0] key_byte_ff;
    logic [6:0] last_code_ff;
    logic last_held_ff;
    logic [7:0] rep_cnt_ff;
    logic rep_fire, combo_any, act_pend_ff;
    logic c_bup, c_bdn, c_cdn, c_cup, c_rst;
    logic [6:0] bri_ff, con_ff;
    logic user_reset_ff, sys_reset_n_ff;
    logic [7:0] rst_cnt_ff;
    logic evt_ff;
    logic [7:0] scan_cnt_ff;
    logic scan_p;
    logic [9:0] adc_arr [4];
    logic [9:0] rd_ff [4];
    logic [9:0] base_ff [4];
    logic [11:0] delta [4];
    logic cal_done_ff;
    logic [4:0] xq, yq;
    logic [7:0] pkt_stat_ff;
    logic [2:0] pkt_x_ff, pkt_y_ff;
    logic sel_ack, sel_key, sel_rep, sel_pkt, snd_busy;
    logic [2:0] snd_len;
    logic [31:0] snd_bytes;
    host_state_t hst_ff;
    logic [7:0] hcmd_ff;
    logic host_take, apb_wr;

    // Zero-wait slave: data latched in setup, error on unmapped
    assign pready = 1'b1;
    assign pslverr = psel && penable &&
        !(paddr == ADDR_CTRL || paddr == ADDR_STATUS);
    assign prdata = prdata_ff;
    assign apb_wr = psel && penable && pwrite && paddr == ADDR_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable) begin
            if (paddr == ADDR_CTRL) begin
                prdata_ff <= {8'h00, scan_ff, int_ff, dly_ff};
            end else if (paddr == ADDR_STATUS) begin
                prdata_ff <= {14'h0000, cal_done_ff, user_reset_ff,
                    1'b0, con_ff, 1'b0, bri_ff};
            end else begin
                prdata_ff <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_ff <= DLY_RST;
            int_ff <= INT_RST;
            scan_ff <= SCAN_RST;
        end else if (apb_wr) begin
            dly_ff <= pwdata[CTRL_DLY_LSB +: 8];
            int_ff <= pwdata[CTRL_INT_LSB +: 8];
            scan_ff <= pwdata[CTRL_SCAN_LSB +: 8];
        end else if (host_take && hst_ff == HOST_ARG) begin
            if (hcmd_ff == CMD_SET_DLY) dly_ff <= host_data;
            else if (hcmd_ff == CMD_SET_INT) int_ff <= host_data;
            else scan_ff <= host_data;
        end
    end

    // Host request parser; operand bytes follow set commands
    assign host_ready = !ack_pend_ff;
    assign host_take = host_valid && host_ready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hst_ff <= HOST_CMD;
            hcmd_ff <= 8'h00;
        end else if (host_take) begin
            case (hst_ff)
                HOST_CMD: begin
                    hcmd_ff <= host_data;
                    if (host_data == CMD_SET_DLY ||
                        host_data == CMD_SET_INT ||
                        host_data == CMD_SET_SCAN) hst_ff <= HOST_ARG;
                end
                default: hst_ff <= HOST_CMD;
            endcase
        end
    end

    // 10ms time base shared by repeat, scan and reset pulse
    assign tick = tick_cnt_ff == 18'(TICK_LEN - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_cnt_ff <= 18'h00000;
        else if (tick) tick_cnt_ff <= 18'h00000;
        else tick_cnt_ff <= tick_cnt_ff + 18'h00001;
    end

    // Key classification
    assign key_ready = !key_pend_ff;
    assign key_take = key_valid && key_ready;
    assign kidx = key_idx(key_code);
    assign intercept = key_take && held_ff[H_ALT] &&
        kidx >= H_UP && kidx <= H_R;
    assign button = key_take && kidx >= H_BL && kidx <= H_BM;
    assign fwd = key_take && !intercept && !button;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) held_ff <= '0;
        else if (key_take && kidx != H_NONE) held_ff[kidx] <= !key_release;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_byte_ff <= 8'h00;
            last_code_ff <= 7'h00;
            last_held_ff <= 1'b0;
        end else if (fwd) begin
            key_byte_ff <= {key_release, key_code};
            if (!key_release) begin
                last_code_ff <= key_code;
                last_held_ff <= 1'b1;
            end else if (key_code == last_code_ff) begin
                last_held_ff <= 1'b0;
            end
        end else if (key_take && !key_release) begin
            last_held_ff <= 1'b0; // Swallowed press is the newest key
        end
    end

    assign c_bup = held_ff[H_ALT] && held_ff[H_UP];
    assign c_bdn = held_ff[H_ALT] && held_ff[H_DOWN];
    assign c_cdn = held_ff[H_ALT] && held_ff[H_LEFT];
    assign c_cup = held_ff[H_ALT] && held_ff[H_RIGHT];
    assign c_rst = held_ff[H_ALT] && held_ff[H_ESC] && held_ff[H_R];
    assign combo_any = c_bup || c_bdn || c_cdn || c_cup || c_rst;

    // repeat timer: delay first, then interval
    assign rep_fire = tick && rep_cnt_ff <= 8'h01 &&
        (combo_any || last_held_ff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rep_cnt_ff <= 8'h00;
        else if (key_take && !key_release) rep_cnt_ff <= dly_ff;
        else if (rep_fire) rep_cnt_ff <= int_ff;
        else if (tick && rep_cnt_ff > 8'h01) rep_cnt_ff <= rep_cnt_ff - 8'h01;
    end

    // combos act on press and on every repeat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) act_pend_ff <= 1'b0;
        else act_pend_ff <= (intercept && !key_release) ||
            (rep_fire && combo_any);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bri_ff <= POT_RST;
            con_ff <= POT_RST;
        end else if (act_pend_ff) begin
            if (c_bup && bri_ff != 7'h00) bri_ff <= bri_ff - 7'h01;
            else if (c_bdn && bri_ff < POT_MAX) bri_ff <= bri_ff + 7'h01;
            if (c_cdn && con_ff != 7'h00) con_ff <= con_ff - 7'h01;
            else if (c_cup && con_ff < POT_MAX) con_ff <= con_ff + 7'h01;
        end
    end
    assign bright_pot = bri_ff;
    assign contrast_pot = con_ff;

    // user reset flag and timed reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_reset_ff <= 1'b0;
            sys_reset_n_ff <= 1'b1;
            rst_cnt_ff <= 8'h00;
        end else if (act_pend_ff && c_rst) begin
            user_reset_ff <= 1'b1;
            sys_reset_n_ff <= 1'b0;
            rst_cnt_ff <= RESET_TICKS;
        end else if (tick && rst_cnt_ff != 8'h00) begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
            sys_reset_n_ff <= rst_cnt_ff == 8'h01;
        end
    end
    assign sys_reset_n = sys_reset_n_ff;
    assign user_reset = user_reset_ff;

    // four channels; baselines caught on first sample
    assign adc_arr[0] = adc_up;
    assign adc_arr[1] = adc_down;
    assign adc_arr[2] = adc_left;
    assign adc_arr[3] = adc_right;
    for (genvar g = 0; g < 4; g++) begin : g_chan
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rd_ff[g] <= 10'h000;
                base_ff[g] <= 10'h000;
            end else if (adc_valid) begin
                rd_ff[g] <= adc_arr[g];
                if (!cal_done_ff) base_ff[g] <= adc_arr[g];
            end
        end
        assign delta[g] = {2'b00, rd_ff[g]} - {2'b00, base_ff[g]};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cal_done_ff <= 1'b0;
        else if (adc_valid) cal_done_ff <= 1'b1;
    end

    assign xq = quant(delta[3] - delta[2]);
    assign yq = quant(delta[0] - delta[1]);

    // Scan pacing in ticks; zero period scans on every tick
    assign scan_p = tick && cal_done_ff && scan_cnt_ff + 8'h01 >= scan_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) scan_cnt_ff <= 8'h00;
        else if (scan_p) scan_cnt_ff <= 8'h00;
        else if (tick) scan_cnt_ff <= scan_cnt_ff + 8'h01;
    end

    // event flag: clear at init, buttons set it; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) evt_ff <= 1'b0;
        else if (button) evt_ff <= 1'b1;
        else if (scan_p) evt_ff <= 1'b0;
    end

    // motion fills status; packet queued at scan end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_pend_ff <= 1'b0;
            pkt_stat_ff <= 8'h00;
            pkt_x_ff <= 3'h0;
            pkt_y_ff <= 3'h0;
        end else if (scan_p && (evt_ff || xq[4] || yq[4])) begin
            pkt_pend_ff <= 1'b1;
            pkt_stat_ff <= {2'b00, yq[4] && yq[3], xq[4] && xq[3],
                1'b1, held_ff[H_BM], held_ff[H_BR], held_ff[H_BL]};
            pkt_x_ff <= xq[4] ? xq[2:0] : 3'h0;
            pkt_y_ff <= yq[4] ? yq[2:0] : 3'h0;
        end else if (sel_pkt) begin
            pkt_pend_ff <= 1'b0;
        end
    end

    // acknowledge ahead of all other traffic
    assign sel_ack = !snd_busy && ack_pend_ff;
    assign sel_key = !snd_busy && !ack_pend_ff && key_pend_ff;
    assign sel_rep = !snd_busy && !ack_pend_ff && !key_pend_ff &&
        rep_pend_ff;
    assign sel_pkt = !snd_busy && !ack_pend_ff && !key_pend_ff &&
        !rep_pend_ff && pkt_pend_ff;

    // Pending sends; a new set beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_pend_ff <= 1'b0;
            key_pend_ff <= 1'b0;
            rep_pend_ff <= 1'b0;
        end else begin
            ack_pend_ff <= (host_take && hst_ff == HOST_CMD) ||
                (ack_pend_ff && !sel_ack);
            key_pend_ff <= fwd || (key_pend_ff && !sel_key);
            rep_pend_ff <= (rep_fire && !combo_any) ||
                (rep_pend_ff && !sel_rep);
        end
    end

    always_comb begin
        snd_len = 3'h0;
        snd_bytes = 32'h00000000;
        if (sel_ack) begin
            snd_len = 3'h1;
            snd_bytes = {ACK_BYTE, 24'h000000};
        end else if (sel_key) begin
            snd_len = 3'h1;
            snd_bytes = {key_byte_ff, 24'h000000};
        end else if (sel_rep) begin
            snd_len = 3'h1;
            snd_bytes = {1'b0, last_code_ff, 24'h000000};
        end else if (sel_pkt) begin
            snd_len = 3'h4;
            snd_bytes = {PKT_HDR, pkt_stat_ff, 5'h00, pkt_x_ff,
                5'h00, pkt_y_ff};
        end
    end

    byte_sender i_byte_sender (
        .pclk(pclk),
        .presetn(presetn),
        .load(snd_len != 3'h0),
        .len(snd_len),
        .bytes(snd_bytes),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .busy(snd_busy)
    );

    // Checks beside the logic share one clock and reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RELEASE_MSB: assert property (fwd && key_release |=>
        key_pend_ff && key_byte_ff[7])
        else $error("release code lacks top bit");
    AST_ACK_BYTE: assert property (sel_ack |=> tx_valid &&
        tx_data == ACK_BYTE)
        else $error("acknowledge byte not sent");
    AST_POT_RANGE: assert property (bri_ff <= POT_MAX &&
        con_ff <= POT_MAX)
        else $error("pot value out of range");
    AST_BRI_UP: assert property (act_pend_ff && c_bup &&
        bri_ff != 7'h00 |=> bri_ff == $past(bri_ff) - 7'h01)
        else $error("brightness step missing");
    AST_USER_RESET: assert property (act_pend_ff && c_rst |=>
        user_reset_ff && !sys_reset_n_ff)
        else $error("reset combo not acted on");
    AST_PKT_HDR: assert property (sel_pkt |=> tx_valid &&
        tx_data == PKT_HDR)
        else $error("packet header wrong");
    AST_OVF_ZERO: assert property (sel_pkt |->
        snd_bytes[23:22] == 2'b00 && snd_bytes[19])
        else $error("overflow bits set");
    AST_SCAN_SEND: assert property (scan_p && evt_ff |=>
        pkt_pend_ff || $past(sel_pkt))
        else $error("flagged scan sent no packet");
endmodule : keyboard_pointer_reporter
`default_nettype wire

//--- sim/host_port_model.sv
// Host serial port model: takes link bytes, issues request bytes
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input wire logic pclk,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic host_valid,
    output logic [7:0] host_data,
    input wire logic host_ready
);
    logic [7:0] rx_q[$];
    logic [1:0] cnt_ff = 2'h0;
    // Idle link, request data parked
    initial begin
        host_valid = 1'b0;
        host_data = 8'h5A;
    end
    // Takes bytes; when slow, only one edge in four to stress hold
    always @(posedge pclk) begin
        cnt_ff <= cnt_ff + 2'h1;
        tx_ready <= !slow || cnt_ff == 2'h3;
        if (tx_valid && tx_ready) rx_q.push_back(tx_data);
    end
    // Request byte; data inverted once released so stale reads show
    task automatic send(input logic [7:0] b);
        host_valid <= 1'b1;
        host_data <= b;
        do @(posedge pclk); while (host_ready !== 1'b1);
        host_valid <= 1'b0;
        host_data <= ~b;
        @(posedge pclk);
    endtask : send
endmodule : host_port_model
`default_nettype wire

//--- sim/keyboard_pointer_reporter_tb.sv
// Self-checking bench for the keyboard pointer reporter
`timescale 1ns/1ps
`default_nettype none
module keyboard_pointer_reporter_tb
    import kpr_pkg::*;
;
    localparam int unsigned TL = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic key_valid, key_release, key_ready, adc_valid, slow;
    logic host_valid, host_ready, tx_valid, tx_ready;
    logic sys_reset_n, user_reset;
    logic [7:0] paddr, host_data, tx_data;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] key_code, bright_pot, contrast_pot;
    logic [9:0] adc_up, adc_down, adc_left, adc_right;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int low_n = 0;
    keyboard_pointer_reporter #(.TICK_LEN(TL)) i_keyboard_pointer_reporter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_valid(key_valid),
        .key_code(key_code), .key_release(key_release),
        .key_ready(key_ready), .adc_valid(adc_valid), .adc_up(adc_up),
        .adc_down(adc_down), .adc_left(adc_left), .adc_right(adc_right),
        .host_valid(host_valid), .host_data(host_data),
        .host_ready(host_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .bright_pot(bright_pot),
        .contrast_pot(contrast_pot), .sys_reset_n(sys_reset_n),
        .user_reset(user_reset));
    host_port_model i_host_port_model (
        .pclk(pclk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .host_valid(host_valid),
        .host_data(host_data), .host_ready(host_ready));
    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Cycle count, hang cut-off, reset pulse width, pad samples
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        adc_valid <= presetn && cyc % 8 == 0;
        if (!sys_reset_n) low_n <= low_n + 1;
        if (cyc == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Setup, access until pready, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic key(input logic [6:0] c, input logic r);
        key_valid <= 1'b1;
        key_code <= c;
        key_release <= r;
        do @(posedge pclk); while (key_ready !== 1'b1);
        key_valid <= 1'b0;
        key_code <= ~c;
        @(posedge pclk);
    endtask : key
    // Compares the first link bytes, then drops the rest
    task automatic rx(input string nm, input logic [7:0] b[$]);
        logic [7:0] g;
        repeat (4000) if (i_host_port_model.rx_q.size() < b.size())
            @(posedge pclk);
        foreach (b[i]) begin
            g = 8'hXX;
            if (i_host_port_model.rx_q.size() > 0)
                g = i_host_port_model.rx_q.pop_front();
            chk(nm, 32'(b[i]), 32'(g));
        end
        i_host_port_model.rx_q.delete();
    endtask : rx
    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl rst", {8'h00, SCAN_RST, INT_RST, DLY_RST}, rd);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status rst", {14'h0, 2'h2, 1'b0, POT_RST, 1'b0, POT_RST}, rd);
        apb(1'b1, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        apb(1'b1, ADDR_CTRL, 32'h0002_0203);
        i_host_port_model.send(CMD_SET_DLY);
        i_host_port_model.send(8'h02);
        i_host_port_model.send(CMD_SET_INT);
        i_host_port_model.send(8'h01);
        i_host_port_model.send(CMD_SET_SCAN);
        i_host_port_model.send(8'h01);
        rx("ack", '{ACK_BYTE, ACK_BYTE, ACK_BYTE});
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h0001_0102, rd);
        $display("regs done");
    endtask : t_regs
    task automatic t_keys();
        int n;
        key(7'h33, 1'b0);
        key(7'h33, 1'b1);
        rx("press release", '{8'h33, 8'hB3});
        key(7'h33, 1'b0);
        repeat (10 * TL) @(posedge pclk);
        key(7'h33, 1'b1);
        repeat (40) @(posedge pclk);
        n = i_host_port_model.rx_q.size() - 2;
        chk("repeats", 32'h1, 32'(n inside {[6:10]}));
        rx("last", '{8'h33});
        $display("keys done");
    endtask : t_keys
    task automatic combo(input logic [6:0] c, input int t);
        key(KC_ALT, 1'b0);
        key(c, 1'b0);
        repeat (t * TL) @(posedge pclk);
        key(c, 1'b1);
        key(KC_ALT, 1'b1);
        rx("alt only", '{8'h38, 8'hB8});
    endtask : combo
    task automatic t_pots();
        combo(KC_UP, 1);
        chk("bright up", 32'h1, 32'(bright_pot < POT_RST));
        combo(KC_UP, 60);
        chk("bright floor", 32'h0, 32'(bright_pot));
        combo(KC_DOWN, 110);
        chk("bright top", 32'(POT_MAX), 32'(bright_pot));
        combo(KC_LEFT, 1);
        chk("contrast", 32'h1, 32'(contrast_pot !== POT_RST));
        key(KC_ALT, 1'b0);
        key(KC_ESC, 1'b0);
        key(KC_R, 1'b0);
        key(KC_R, 1'b1);
        key(KC_ESC, 1'b1);
        key(KC_ALT, 1'b1);
        rx("alt only", '{8'h38, 8'hB8});
        repeat (12 * TL) @(posedge pclk);
        chk("user reset", 32'h1, 32'(user_reset));
        chk("pulse", 32'h1, 32'(low_n inside {[9 * TL:10 * TL + 1]}));
        $display("pots done");
    endtask : t_pots
    task automatic ptr(input logic [9:0] u, d, l, r, logic [7:0] s, x, y);
        {adc_up, adc_down, adc_left, adc_right} <= {u, d, l, r} + {4{10'h200}};
        repeat (4000) if (i_host_port_model.rx_q.size() < 4)
            @(posedge pclk);
        {adc_up, adc_down, adc_left, adc_right} <= {4{10'h200}};
        repeat (3 * TL) @(posedge pclk);
        rx("packet", '{PKT_HDR, s, x, y});
    endtask : ptr
    task automatic t_ptr();
        slow <= 1'b1;
        ptr(10'd0, 10'd0, 10'd0, 10'd40, 8'h08, 8'h04, 8'h00);
        ptr(10'd0, 10'd0, 10'd40, 10'd0, 8'h18, 8'h04, 8'h00);
        ptr(10'd80, 10'd0, 10'd0, 10'd0, 8'h08, 8'h00, 8'h07);
        ptr(10'd0, 10'd16, 10'd0, 10'd0, 8'h28, 8'h00, 8'h01);
        adc_right <= 10'h207;
        repeat (5 * TL) @(posedge pclk);
        chk("no packet", 32'h0, 32'(i_host_port_model.rx_q.size()));
        adc_right <= 10'h200;
        key(KC_BTN_L, 1'b0);
        rx("button", '{PKT_HDR, 8'h09, 8'h00, 8'h00});
        key(KC_BTN_L, 1'b1);
        rx("button up", '{PKT_HDR, 8'h08, 8'h00, 8'h00});
        $display("pointer done");
    endtask : t_ptr
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // Reset for 20 cycles, settle past calibration, then the tests
    initial begin
        {presetn, psel, penable, pwrite, key_valid, key_release, slow} = '0;
        {paddr, pwdata, key_code} = '0;
        {adc_up, adc_down, adc_left, adc_right} = {4{10'h200}};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        t_regs();
        t_keys();
        t_pots();
        t_ptr();
        wrap_up();
    end
endmodule : keyboard_pointer_reporter_tb
`default_nettype wire
